// [src/sut_timer.sv]
`timescale 1ns/10ps
`include "sut_cfg.svh"
// Summary of operation
// - Underflow with reset enabled asserts system reset
// - Only power-on reset clears timer state
// - Configuration bit seven enables underflow reset
// - Timer runs after power-on or watchdog reset
// - Run bit two starts, stops; power-on and watchdog resets set
// - Reset disabled: plain timer, interrupt via enable
// - Reset enable zero ignores safety bit
// - Reset on, safety off: clock select free
// - Safety forces clock, run; single write
// - Thirteen-bit prescaler feeds eight-bit down counter
// - Prescaler clock is peripheral or oscillator
// - Clock select change takes effect delayed
// - Reset mode: new values need feed
// - Timer reset held one watchdog clock
// - Execution restarts right after reset cycle
// - Powered down: wait oscillator stable first
// - Feed is A5 then 5A; bad feed resets
// - Reads allowed mid-feed; writes break feed
// - Valid feed loads counter and shadow control
// - Timer mode copies control every cycle
module sut_timer (
   // Clock and resets
   input  wire logic                 i_clock,
   input  wire logic                 i_rst,
   input  wire logic                 i_por,
   // Clock sources as one-cycle enables
   input  wire logic                 i_pclk_en,
   input  wire logic                 i_wdosc_en,
   // Power state
   input  wire logic                 i_powered_down,
   // Register port
   input  wire sut_pkg::sut_bus_req_t i_bus,
   output logic [7:0]                o_rdata,
   // System outputs
   output logic                      o_sys_reset,
   output logic                      o_osc_start,
   output logic                      o_irq
);
   logic [7:0] ctrl_reg;
   logic [7:0] shadow;
   logic [7:0] reload;
   logic [7:0] ucfg;
   logic [7:0] interrupt_enable_reg_zero;
   logic [7:0] down;
   logic       tof;
   logic       feed_armed;
   logic       ctrl_dirty;
   logic       locked_written;
   logic       clk_sel_eff;
   logic [2:0] switch_cnt;
   logic       wd_tick;
   logic       tap;
   logic       underflow;
   logic       rst_en;
   logic       safe;
   logic       run_eff;
   logic       sel_req;
   logic       wr_ctrl;
   logic       wr_reload;
   logic       wr_feed1;
   logic       wr_feed2;
   logic       good_feed;
   logic       bad_feed;
   logic       wd_reset_req;
   logic [4:0] stable_cnt;
   sut_pkg::sut_rst_state_t rst_state;

   assign rst_en = ucfg[`SUT_UCFG_RST_EN];
   assign safe   = rst_en && ucfg[`SUT_UCFG_SAFE];
   assign run_eff = safe ? 1'b1 : shadow[`SUT_CTRL_RUN];
   assign sel_req = safe ? 1'b1 : shadow[`SUT_CTRL_CLKSEL];

   assign wr_ctrl   = i_bus.wr && i_bus.addr == `SUT_ADDR_CTRL;
   assign wr_reload = i_bus.wr && i_bus.addr == `SUT_ADDR_RELOAD;
   assign wr_feed1  = i_bus.wr && i_bus.addr == `SUT_ADDR_FEED1
                      && i_bus.wdata == `SUT_FEED1_VAL;
   assign wr_feed2  = i_bus.wr && i_bus.addr == `SUT_ADDR_FEED2;
   assign good_feed = feed_armed && wr_feed2
                      && i_bus.wdata == `SUT_FEED2_VAL;
   assign bad_feed = (feed_armed && i_bus.wr && !good_feed)
                     || (!feed_armed && i_bus.wr
                         && (i_bus.addr == `SUT_ADDR_FEED2
                             || (i_bus.addr == `SUT_ADDR_FEED1
                                 && !wr_feed1)));

   assign wd_tick = run_eff && (clk_sel_eff ? i_wdosc_en : i_pclk_en);

   sut_prescaler #(
      .WIDTH(13)
   ) u_pre (
      .i_clock   (i_clock),
      .i_rst     (i_por),
      .i_tick    (wd_tick),
      .i_clear   (good_feed),
      .i_tap_sel (shadow[`SUT_CTRL_PRE_HI:`SUT_CTRL_PRE_LO]),
      .o_tap     (tap)
   );

   assign underflow = tap && down == 8'h00;

   assign wd_reset_req = rst_en && (underflow || (bad_feed && rst_en)
                         || (ctrl_dirty && i_bus.wr && !wr_feed1
                             && !feed_armed && !wr_ctrl));

   // Software copies; only power-on reset touches them
   always_ff @(posedge i_clock or posedge i_por) begin
      if (i_por) begin
         ctrl_reg       <= `SUT_CTRL_RESET;
         reload         <= `SUT_RELOAD_RESET;
         ucfg           <= 8'h00;
         interrupt_enable_reg_zero           <= 8'h00;
         locked_written <= 1'b0;
      end else begin
         if ((wr_ctrl || wr_reload) && !(safe && locked_written)) begin
            locked_written <= 1'b1;
            if (wr_ctrl) begin
               ctrl_reg <= i_bus.wdata;
            end else begin
               reload <= i_bus.wdata;
            end
         end
         if (i_bus.wr && i_bus.addr == `SUT_ADDR_UCFG) begin
            ucfg <= i_bus.wdata;
         end
         if (i_bus.wr && i_bus.addr == `SUT_ADDR_INTERRUPT_ENABLE_REG_ZERO) begin
            interrupt_enable_reg_zero <= i_bus.wdata;
         end
      end
   end

   // Shadow control and down counter
   always_ff @(posedge i_clock or posedge i_por) begin
      if (i_por) begin
         shadow <= `SUT_CTRL_RESET;
         down   <= `SUT_RELOAD_RESET;
      end else begin
         if (good_feed || !rst_en) begin
            shadow <= ctrl_reg;
         end
         if (o_sys_reset) begin
            shadow[`SUT_CTRL_RUN] <= 1'b1;
         end
         if (good_feed) begin
            down <= reload;
         end else if (tap) begin
            down <= down - 8'h01;
         end
      end
   end

   // Feed sequencing
   always_ff @(posedge i_clock or posedge i_por) begin
      if (i_por) begin
         feed_armed <= 1'b0;
         ctrl_dirty <= 1'b0;
      end else begin
         if (wr_feed1 && !feed_armed) begin
            feed_armed <= 1'b1;
         end else if (i_bus.wr) begin
            feed_armed <= 1'b0;
         end
         if (good_feed) begin
            ctrl_dirty <= 1'b0;
         end else if (wr_ctrl && rst_en) begin
            ctrl_dirty <= 1'b1;
         end
      end
   end

   // Timeout flag, set wins over a clear by a control write
   always_ff @(posedge i_clock or posedge i_por) begin
      if (i_por) begin
         tof <= 1'b0;
      end else if (underflow) begin
         tof <= 1'b1;
      end else if (wr_ctrl && !i_bus.wdata[`SUT_CTRL_TOF]) begin
         tof <= 1'b0;
      end
   end

   // Delayed clock source switch
   always_ff @(posedge i_clock or posedge i_por) begin
      if (i_por) begin
         clk_sel_eff <= 1'b1;
         switch_cnt  <= 3'h0;
      end else if (sel_req == clk_sel_eff) begin
         switch_cnt <= 3'h0;
      end else if (switch_cnt == 3'(`SUT_SWITCH_CYC - 1)) begin
         clk_sel_eff <= sel_req;
         switch_cnt  <= 3'h0;
      end else begin
         switch_cnt <= switch_cnt + 3'h1;
      end
   end

   // Reset generation
   always_ff @(posedge i_clock or posedge i_por) begin
      if (i_por) begin
         rst_state  <= sut_pkg::SUT_RUN;
         stable_cnt <= 5'h00;
      end else begin
         unique case (rst_state)
            sut_pkg::SUT_RUN: begin
               if (wd_reset_req) begin
                  rst_state <= sut_pkg::SUT_RST;
               end
            end
            sut_pkg::SUT_RST: begin
               if (clk_sel_eff ? i_wdosc_en : i_pclk_en) begin
                  if (i_powered_down) begin
                     rst_state  <= sut_pkg::SUT_WAIT;
                     stable_cnt <= 5'h00;
                  end else begin
                     rst_state <= sut_pkg::SUT_RUN;
                  end
               end
            end
            sut_pkg::SUT_WAIT: begin
               if (stable_cnt == 5'(`SUT_OSC_STABLE - 1)) begin
                  rst_state <= sut_pkg::SUT_RUN;
               end else begin
                  stable_cnt <= stable_cnt + 5'h01;
               end
            end
            default: begin
               rst_state <= sut_pkg::SUT_RUN;
            end
         endcase
      end
   end

   assign o_sys_reset = rst_state != sut_pkg::SUT_RUN;
   assign o_osc_start = rst_state == sut_pkg::SUT_WAIT;
   assign o_irq = !rst_en && tof && interrupt_enable_reg_zero[`SUT_INTERRUPT_ENABLE_REG_ZERO_TMR];

   // Read data one cycle later
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_bus.rd) begin
         unique case (i_bus.addr)
            `SUT_ADDR_CTRL:   o_rdata <= {ctrl_reg[7:5], 2'b00, run_eff,
                                          tof, clk_sel_eff};
            `SUT_ADDR_RELOAD: o_rdata <= reload;
            `SUT_ADDR_UCFG:   o_rdata <= ucfg;
            `SUT_ADDR_INTERRUPT_ENABLE_REG_ZERO:   o_rdata <= interrupt_enable_reg_zero;
            `SUT_ADDR_STATUS: o_rdata <= down;
            default:          o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule : sut_timer

// [src/sut_cfg.svh]
`ifndef SUT_CFG_SVH
`define SUT_CFG_SVH
// Register addresses on the plain port
`define SUT_ADDR_CTRL     8'h00
`define SUT_ADDR_RELOAD   8'h01
`define SUT_ADDR_FEED1    8'h02
`define SUT_ADDR_FEED2    8'h03
`define SUT_ADDR_UCFG     8'h04
`define SUT_ADDR_INTERRUPT_ENABLE_REG_ZERO     8'h05
`define SUT_ADDR_STATUS   8'h06
// Control register fields
`define SUT_CTRL_PRE_HI   7
`define SUT_CTRL_PRE_LO   5
`define SUT_CTRL_RUN      2
`define SUT_CTRL_TOF      1
`define SUT_CTRL_CLKSEL   0
// Configuration and enable fields
`define SUT_UCFG_RST_EN   7
`define SUT_UCFG_SAFE     4
`define SUT_INTERRUPT_ENABLE_REG_ZERO_TMR      6
// Reset values
`define SUT_CTRL_RESET    8'hE5
`define SUT_RELOAD_RESET  8'hFF
// Feed patterns
`define SUT_FEED1_VAL     8'hA5
`define SUT_FEED2_VAL     8'h5A
// Clock switch delay and reset hold
`define SUT_SWITCH_CYC    4
`define SUT_OSC_STABLE    16
`endif

// [src/sut_pkg.sv]
package sut_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sut_bus_req_t;

   typedef enum logic [1:0] {
      SUT_RUN  = 2'b00,
      SUT_RST  = 2'b01,
      SUT_WAIT = 2'b10
   } sut_rst_state_t;
endpackage : sut_pkg

// [src/sut_prescaler.sv]
`timescale 1ns/10ps
`include "sut_cfg.svh"
module sut_prescaler #(
   parameter int WIDTH = 13
) (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   // Count control
   input  wire logic       i_tick,
   input  wire logic       i_clear,
   input  wire logic [2:0] i_tap_sel,
   // Tap pulse
   output logic            o_tap
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic [3:0]       tap_bit;

   assign next_count = count + 1'b1;
   // Taps at bits 5,6..12 selected by three prescale bits
   assign tap_bit = 4'(i_tap_sel) + 4'h5;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         count <= '0;
      end else if (i_clear) begin
         count <= '0;
      end else if (i_tick) begin
         count <= next_count;
      end
   end

   // A tap fires when the chosen bit rolls over to zero
   assign o_tap = i_tick && !i_clear && count[tap_bit]
                  && !next_count[tap_bit];
endmodule : sut_prescaler

// [dv/sut_chk.sv]
`timescale 1ns/10ps
module sut_chk (
   // Clock and resets
   input wire logic                  i_clock,
   input wire logic                  i_rst,
   input wire logic                  i_por,
   // Inputs
   input wire logic                  i_pclk_en,
   input wire logic                  i_wdosc_en,
   input wire logic                  i_powered_down,
   input wire sut_pkg::sut_bus_req_t i_bus,
   // Outputs
   input wire logic [7:0]            o_rdata,
   input wire logic                  o_sys_reset,
   input wire logic                  o_osc_start,
   input wire logic                  o_irq
);
   logic [7:0] ucfg;
   logic       ien;
   logic       armed;
   // Mirror of configuration, enable and feed progress
   always_ff @(posedge i_clock or posedge i_por) begin
      if (i_por) begin
         ucfg  <= 8'h00;
         ien   <= 1'b0;
         armed <= 1'b0;
      end else begin
         if (i_bus.wr && i_bus.addr == 8'h04) ucfg <= i_bus.wdata;
         if (i_bus.wr && i_bus.addr == 8'h05) ien <= i_bus.wdata[6];
         if (o_sys_reset) armed <= 1'b0;
         else if (i_bus.wr)
            armed <= i_bus.addr == 8'h02 && i_bus.wdata == 8'hA5;
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_por);
   AST_BAD_FEED1: assert property (
      i_bus.wr && i_bus.addr == 8'h02 && i_bus.wdata != 8'hA5 && ucfg[7]
      && !o_sys_reset |=> o_sys_reset) else $error("bad first feed kept");
   AST_BAD_FEED2: assert property (
      i_bus.wr && i_bus.addr == 8'h03 && !(armed && i_bus.wdata == 8'h5A)
      && ucfg[7] && !o_sys_reset |=> o_sys_reset) else $error("bad feed2");
   AST_MID_WRITE: assert property (
      armed && i_bus.wr && i_bus.addr != 8'h03 && ucfg[7] && !o_sys_reset
      |=> o_sys_reset) else $error("write inside feed kept");
   AST_TIMER_QUIET: assert property (
      !ucfg[7] && !$past(ucfg[7]) |-> !o_sys_reset)
      else $error("reset in timer mode");
   AST_IRQ_MODE: assert property (
      o_irq |-> !ucfg[7] && ien) else $error("irq outside timer mode");
   AST_RST_HOLD: assert property (
      o_sys_reset && !o_osc_start && !i_pclk_en && !i_wdosc_en
      |=> o_sys_reset)
      else $error("reset ended without clock");
   AST_OSC_IN_RST: assert property (
      o_osc_start |-> o_sys_reset) else $error("osc wait outside reset");
   AST_OSC_HOLD: assert property (
      $rose(o_osc_start) |-> o_osc_start[*8]) else $error("osc wait short");
   AST_UCFG_READ: assert property (
      i_bus.rd && i_bus.addr == 8'h04 && !i_rst
      |=> o_rdata[7] == $past(ucfg[7])) else $error("ucfg read wrong");
endmodule : sut_chk
bind sut_timer sut_chk u_chk (.i_clock(i_clock), .i_rst(i_rst),
   .i_por(i_por), .i_pclk_en(i_pclk_en), .i_wdosc_en(i_wdosc_en),
   .i_powered_down(i_powered_down), .i_bus(i_bus), .o_rdata(o_rdata),
   .o_sys_reset(o_sys_reset), .o_osc_start(o_osc_start), .o_irq(o_irq));

// [dv/sut_cpu.sv]
`timescale 1ns/10ps
`include "sut_cfg.svh"
module sut_cpu (
   // Clock
   input  wire logic             i_clock,
   // Register port
   output sut_pkg::sut_bus_req_t o_bus,
   input  wire logic [7:0]       i_rdata
);
   initial o_bus = '0;
   // Released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clock);
      o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clock);
      o_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clock);
      o_bus <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      #1 d = i_rdata;
   endtask : rd
   // Feed pair, nothing written between
   task automatic feed();
      wr(`SUT_ADDR_FEED1, `SUT_FEED1_VAL);
      wr(`SUT_ADDR_FEED2, `SUT_FEED2_VAL);
   endtask : feed
endmodule : sut_cpu

// [dv/tb_top.sv]
`timescale 1ns/10ps
`include "sut_cfg.svh"
module tb_top;
   logic                  i_clock = 1'b0;
   logic                  i_rst = 1'b1;
   logic                  i_por = 1'b1;
   logic                  i_pclk_en = 1'b0;
   logic                  i_wdosc_en = 1'b0;
   logic                  i_powered_down = 1'b0;
   sut_pkg::sut_bus_req_t bus;
   logic [7:0]            rdata, v, w;
   logic                  sys_rst, osc, irq;
   logic [2:0]            div = 3'h0;
   int                    num_errors = 0, n_tests = 0, cyc = 0;
   always #2 i_clock = ~i_clock;
   sut_timer DUT (.i_clock(i_clock), .i_rst(i_rst), .i_por(i_por),
      .i_pclk_en(i_pclk_en), .i_wdosc_en(i_wdosc_en),
      .i_powered_down(i_powered_down), .i_bus(bus), .o_rdata(rdata),
      .o_sys_reset(sys_rst), .o_osc_start(osc), .o_irq(irq));
   sut_cpu cpu (.i_clock(i_clock), .o_bus(bus), .i_rdata(rdata));
   task automatic print_verdict();
      $display("Checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   // Clock enables and run limit
   always @(posedge i_clock) begin
      div <= div + 3'h1;
      i_pclk_en <= div[0];
      i_wdosc_en <= div == 3'h7;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic check(input string s, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   // Waits up to n cycles for a level, then compares
   task automatic wait_lvl(input string s, ref logic x, input logic l,
                           input int n);
      int k;
      k = 0;
      while (x !== l && k < n) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      check(s, 8'(x), 8'(l));
   endtask : wait_lvl
   task automatic por();
      @(posedge i_clock);
      i_por <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_por <= 1'b0;
   endtask : por
   initial begin
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      i_por <= 1'b0;
      cpu.rd(`SUT_ADDR_CTRL, v);
      check("ctrl", v, `SUT_CTRL_RESET);
      cpu.rd(`SUT_ADDR_RELOAD, v);
      check("reload", v, `SUT_RELOAD_RESET);
      // Timer mode, fastest tap, peripheral clock
      cpu.wr(`SUT_ADDR_INTERRUPT_ENABLE_REG_ZERO, 8'h40);
      cpu.wr(`SUT_ADDR_RELOAD, 8'h02);
      cpu.wr(`SUT_ADDR_CTRL, 8'h04);
      cpu.feed();
      wait_lvl("irq", irq, 1'b1, 1000);
      check("no reset", 8'(sys_rst), 8'h00);
      cpu.wr(`SUT_ADDR_CTRL, 8'h00);
      cpu.feed();
      wait_lvl("irq clear", irq, 1'b0, 2);
      cpu.rd(`SUT_ADDR_STATUS, v);
      repeat (300) @(posedge i_clock);
      cpu.rd(`SUT_ADDR_STATUS, w);
      check("stopped", w, v);
      @(posedge i_clock);
      i_rst <= 1'b1;
      @(posedge i_clock);
      i_rst <= 1'b0;
      cpu.rd(`SUT_ADDR_CTRL, v);
      check("ctrl kept", v, 8'h00);
      // Watchdog mode faults
      por();
      cpu.wr(`SUT_ADDR_UCFG, 8'h80);
      cpu.rd(`SUT_ADDR_UCFG, v);
      check("ucfg7", 8'(v[7]), 8'h01);
      cpu.wr(`SUT_ADDR_FEED1, `SUT_FEED1_VAL);
      cpu.rd(`SUT_ADDR_STATUS, v);
      check("read in feed", 8'(sys_rst), 8'h00);
      cpu.wr(`SUT_ADDR_RELOAD, 8'h10);
      wait_lvl("write in feed", sys_rst, 1'b1, 2);
      wait_lvl("reset end", sys_rst, 1'b0, 100);
      cpu.wr(`SUT_ADDR_FEED1, 8'h11);
      wait_lvl("bad feed1", sys_rst, 1'b1, 2);
      wait_lvl("reset end", sys_rst, 1'b0, 100);
      i_powered_down <= 1'b1;
      cpu.wr(`SUT_ADDR_FEED2, `SUT_FEED2_VAL);
      wait_lvl("osc wait", osc, 1'b1, 100);
      wait_lvl("osc reset end", sys_rst, 1'b0, 200);
      i_powered_down <= 1'b0;
      cpu.wr(`SUT_ADDR_RELOAD, 8'h01);
      cpu.wr(`SUT_ADDR_CTRL, 8'h04);
      cpu.feed();
      check("good feed", 8'(sys_rst), 8'h00);
      cpu.rd(`SUT_ADDR_CTRL, v);
      check("sel delayed", 8'(v[0]), 8'h01);
      repeat (4) @(posedge i_clock);
      cpu.rd(`SUT_ADDR_CTRL, v);
      check("sel free", 8'(v[0]), 8'h00);
      wait_lvl("underflow", sys_rst, 1'b1, 1000);
      // Safety lock, second control write refused
      por();
      cpu.wr(`SUT_ADDR_UCFG, 8'h90);
      cpu.wr(`SUT_ADDR_CTRL, 8'h04);
      cpu.feed();
      cpu.wr(`SUT_ADDR_CTRL, 8'hE4);
      cpu.feed();
      cpu.rd(`SUT_ADDR_CTRL, v);
      check("one write", 8'(v[7:5]), 8'h00);
      check("forced sel", 8'(v[0]), 8'h01);
      check("forced run", 8'(v[2]), 8'h01);
      print_verdict();
   end
endmodule : tb_top
